// ---- nbh_pkg.sv ----
// nbh_pkg: shared constants and carrier types for the nand bus host
// assumes a single 50 MHz core clock; no timescale here
package nbh_pkg;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned POWERUP_WAIT_US = 10;
  localparam int unsigned POWERUP_CYCLES = (POWERUP_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned GLITCH_NS = 5;
  localparam int unsigned STROBE_MIN_CYCLES = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] STROBE_HALF_CYCLES = 4'h2;
  localparam logic [2:0] ADDR_CYCLES = 3'h5;
  localparam int unsigned PAGES_PER_BLOCK = 64;
  localparam int unsigned PAGE_MAIN_BYTES = 2048;
  localparam int unsigned PAGE_SPARE_BYTES = 64;
  localparam logic [15:0] POWERUP_RESET_CNT = 16'h0000;

  typedef enum logic [2:0] {
    NBH_OP_CMD = 3'h0,
    NBH_OP_ADDR = 3'h1,
    NBH_OP_DIN = 3'h2,
    NBH_OP_DOUT = 3'h3,
    NBH_OP_IDLE = 3'h4
  } nbh_op_t;

  typedef struct packed {
    nbh_op_t op;
    logic [7:0] data;
    logic last;
  } nbh_req_t;

  typedef struct packed {
    logic chip_sel_n;
    logic cmd_latch_en;
    logic addr_latch_en;
    logic write_n;
    logic read_n;
    logic [7:0] bus_out;
    logic bus_oe_n;
  } nbh_pins_t;
endpackage

// ---- nbh_strobe.sv ----
// nbh_strobe: times one strobe pulse low then high, never shorter than the glitch floor
// assumes the caller holds start for one cycle only while idle
`timescale 1ns/1ps
`default_nettype none
module nbh_strobe
  import nbh_pkg::*;
#(
  parameter logic [3:0] HALF = STROBE_HALF_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic start,
  output logic low,
  output logic mid,
  output logic done
);
  logic [4:0] cnt_reg;
  logic [4:0] cnt_next;
  wire logic busy = cnt_reg != 5'h00;
  wire logic [4:0] full = {HALF, 1'b0};
  assign cnt_next = start ? full : (busy ? cnt_reg - 5'h01 : 5'h00);
  assign low = busy && (cnt_reg > {1'b0, HALF});
  assign mid = busy && (cnt_reg == {1'b0, HALF} + 5'h01);
  assign done = cnt_reg == 5'h01;
  always_ff @(posedge clk) begin
    if (!rst_n) cnt_reg <= 5'h00;
    else if (ce) cnt_reg <= cnt_next;
  end
endmodule
`default_nettype wire

// ---- nbh_host.sv ----
// nbh_host: host-side controller that drives the multiplexed 8-bit nand bus pins
// assumes all pin inputs are synchronous to CORE_CLK and the busy line has a pull-up
// Functional notes
// - host waits 10 us after power-up, keeping write strobe high
// - host holds write guard low through power transitions
// - busy line is open drain; host treats low as someone busy
// - host sends at most five address cycles after each command, refusing and flagging a sixth
// - host holds write guard high whenever PROG_ALLOWED is set after power-up, whatever command it issues
`timescale 1ns/1ps
`default_nettype none
module nbh_host
  import nbh_pkg::*;
#(
  parameter int unsigned PWR_WAIT = POWERUP_CYCLES,
  parameter logic [3:0] HALF = STROBE_HALF_CYCLES
) (
  // clock, reset, enable
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire logic CLK_EN,
  // user request side
  input wire logic REQ_VALID,
  input wire nbh_req_t REQ,
  input wire logic PROG_ALLOWED,
  input wire logic LOCK_MODE,
  output logic REQ_READY,
  output logic RSP_VALID,
  output logic [7:0] RSP_DATA,
  output logic ADDR_COUNT_ERR,
  output logic POWER_OK,
  output logic DEV_BUSY,
  // nand pins
  output logic CHIP_SEL_N,
  output logic CMD_LATCH_EN,
  output logic ADDR_LATCH_EN,
  output logic WRITE_N,
  output logic READ_N,
  output logic WRITE_GUARD_N,
  output logic LOCK_FEATURE_EN,
  output logic [7:0] BUS_LINES_OUT,
  output logic BUS_LINES_OE_N,
  input wire logic [7:0] BUS_LINES_IN,
  input wire logic READY_BUSY_N
);
  typedef enum logic [3:0] {
    ST_PWR = 4'b0001,
    ST_IDLE = 4'b0010,
    ST_WR = 4'b0100,
    ST_RD = 4'b1000
  } nbh_state_t;

  nbh_state_t state_reg, state_next;
  logic [15:0] pwr_cnt_reg;
  logic [2:0] addr_cnt_reg;
  nbh_req_t req_reg;
  nbh_pins_t pins_reg, pins_next;
  logic busy_s_reg;
  logic st_start, st_low, st_mid, st_done;

  // one transfer, counted from the take cycle:
  //   the take edge loads select, latches, data and the strobe going low
  //   the strobe stays low for HALF cycles, then high for HALF cycles
  //   select returns high on the edge that ends the high half
  // latches and data stand across the strobe's rising edge, so the
  // device latches them settled; HALF of one cycle would still clear
  // the glitch floor at this clock, two leaves margin for board skew
  nbh_strobe #(.HALF(HALF)) u_strobe (
    .clk(CORE_CLK),
    .rst_n(RST_B),
    .ce(CLK_EN),
    .start(st_start),
    .low(st_low),
    .mid(st_mid),
    .done(st_done)
  );

  // one pulse per byte, low and high halves at least a glitch floor wide
  wire logic pwr_done = pwr_cnt_reg == 16'(PWR_WAIT);
  wire logic take = (state_reg == ST_IDLE) && REQ_VALID && !busy_s_reg;
  wire logic is_wr_op = REQ.op inside {NBH_OP_CMD, NBH_OP_ADDR, NBH_OP_DIN};
  wire logic is_rd_op = REQ.op == NBH_OP_DOUT;
  // the device drops extra address cycles anyway; we refuse and flag them
  wire logic addr_over = REQ.op == NBH_OP_ADDR && addr_cnt_reg == ADDR_CYCLES;
  assign st_start = take && (is_wr_op || is_rd_op) && !addr_over;
  wire logic wr_low = (state_reg == ST_WR) && st_low;
  wire logic rd_low = (state_reg == ST_RD) && st_low;
  wire logic end_xfer = st_done && (state_reg == ST_WR || state_reg == ST_RD);
  wire logic rd_sample = (state_reg == ST_RD) && st_mid;
  // ready also waits for the busy line, so a shown ready is a taken request
  wire logic ready_next = (state_next == ST_IDLE) && !st_start && !end_xfer && READY_BUSY_N;
  // the address count restarts with every command
  wire logic addr_clear = st_start && REQ.op == NBH_OP_CMD;
  wire logic addr_step = st_start && REQ.op == NBH_OP_ADDR;


  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_PWR: begin
        if (pwr_done) state_next = ST_IDLE;
      end
      ST_IDLE: begin
        if (st_start) state_next = is_rd_op ? ST_RD : ST_WR;
      end
      ST_WR, ST_RD: begin
        if (st_done) state_next = ST_IDLE;
      end
    endcase
  end

  wire nbh_req_t cur = (state_reg == ST_IDLE) ? REQ : req_reg;
  wire logic active = state_next == ST_WR || state_next == ST_RD;
  always_comb begin
    pins_next.chip_sel_n = 1'b1;
    pins_next.cmd_latch_en = 1'b0;
    pins_next.addr_latch_en = 1'b0;
    pins_next.write_n = 1'b1;
    pins_next.read_n = 1'b1;
    pins_next.bus_out = 8'h00;
    pins_next.bus_oe_n = 1'b1;
    if (active) begin
      pins_next.chip_sel_n = 1'b0;
      if (state_next == ST_WR) begin
        // latches set on the same edge write falls and held past its rise
        pins_next.cmd_latch_en = cur.op == NBH_OP_CMD;
        pins_next.addr_latch_en = cur.op == NBH_OP_ADDR;
        pins_next.write_n = !(wr_low || st_start) || st_mid;
        pins_next.bus_out = cur.data;
        pins_next.bus_oe_n = 1'b0;
      end else begin
        pins_next.read_n = !(rd_low || st_start) || st_mid;
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      state_reg <= ST_PWR;
      pwr_cnt_reg <= POWERUP_RESET_CNT;
      // pins park in standby with both strobes high
      pins_reg.chip_sel_n <= 1'b1;
      pins_reg.cmd_latch_en <= 1'b0;
      pins_reg.addr_latch_en <= 1'b0;
      pins_reg.write_n <= 1'b1;
      pins_reg.read_n <= 1'b1;
      pins_reg.bus_out <= 8'h00;
      pins_reg.bus_oe_n <= 1'b1;
      req_reg.op <= NBH_OP_IDLE;
      req_reg.data <= 8'h00;
      req_reg.last <= 1'b0;
      addr_cnt_reg <= 3'h0;
      busy_s_reg <= 1'b1;
    end else if (CLK_EN) begin
      state_reg <= state_next;
      // stops at the wait so it never wraps back into it
      if (!pwr_done) pwr_cnt_reg <= pwr_cnt_reg + 16'h0001;
      pins_reg <= pins_next;
      // one flop of delay on the shared busy line; ready_next reads the pin itself
      busy_s_reg <= !READY_BUSY_N;
      if (st_start) req_reg <= REQ;
      if (addr_clear) addr_cnt_reg <= 3'h0;
      else if (addr_step) addr_cnt_reg <= addr_cnt_reg + 3'h1;
    end
  end

  // user-side outputs plus the guard and lock pins, all registered
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      REQ_READY <= 1'b0;
      RSP_VALID <= 1'b0;
      RSP_DATA <= 8'h00;
      ADDR_COUNT_ERR <= 1'b0;
      POWER_OK <= 1'b0;
      DEV_BUSY <= 1'b1;
      WRITE_GUARD_N <= 1'b0;
      LOCK_FEATURE_EN <= 1'b0;
    end else if (CLK_EN) begin
      REQ_READY <= ready_next;
      RSP_VALID <= rd_sample;
      // read byte taken at the end of the low half, where the device drives it
      if (rd_sample) RSP_DATA <= BUS_LINES_IN;
      ADDR_COUNT_ERR <= take && addr_over;
      POWER_OK <= pwr_done;
      DEV_BUSY <= busy_s_reg;
      // guard driven straight from the enable, low until power settled
      // no strobe latches it, so it falls one cycle after PROG_ALLOWED does
      WRITE_GUARD_N <= pwr_done && PROG_ALLOWED;
      // plain registered copy; the device reads the lock pin as a level
      LOCK_FEATURE_EN <= LOCK_MODE;
    end
  end

  assign CHIP_SEL_N = pins_reg.chip_sel_n;
  assign CMD_LATCH_EN = pins_reg.cmd_latch_en;
  assign ADDR_LATCH_EN = pins_reg.addr_latch_en;
  assign WRITE_N = pins_reg.write_n;
  assign READ_N = pins_reg.read_n;
  assign BUS_LINES_OUT = pins_reg.bus_out;
  assign BUS_LINES_OE_N = pins_reg.bus_oe_n;
  // geometry only shapes the user's addressing: 64 pages, 2048+64 bytes
  // power-up read mode needs no command from us
endmodule
`default_nettype wire

// ---- nbh_host_properties.sv ----
// nbh_host_properties: pin checks for nbh_host
// assumes it is bound to nbh_host with CLK_EN held high
`timescale 1ns/1ps
`default_nettype none
module nbh_host_properties (
  // clock, reset, user side
  input wire logic CORE_CLK, RST_B, LOCK_MODE, POWER_OK, DEV_BUSY,
  // nand pins
  input wire logic CHIP_SEL_N, CMD_LATCH_EN, ADDR_LATCH_EN, WRITE_N, READ_N,
  input wire logic WRITE_GUARD_N, LOCK_FEATURE_EN, BUS_LINES_OE_N, READY_BUSY_N
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  property p_wwen; !POWER_OK |-> WRITE_N; endproperty
  a_wwen: assert property (p_wwen) else $error("write strobe low in wait");
  property p_wgrd; !POWER_OK |-> !WRITE_GUARD_N; endproperty
  a_wgrd: assert property (p_wgrd) else $error("guard high in wait");
  property p_cmd; $rose(WRITE_N) && CMD_LATCH_EN |-> !CHIP_SEL_N && !ADDR_LATCH_EN && READ_N;
  endproperty
  a_cmd: assert property (p_cmd) else $error("bad command cycle");
  property p_adr; $rose(WRITE_N) && ADDR_LATCH_EN |-> !CHIP_SEL_N && !CMD_LATCH_EN && READ_N;
  endproperty
  a_adr: assert property (p_adr) else $error("bad address cycle");
  property p_din; $rose(WRITE_N) && !CMD_LATCH_EN && !ADDR_LATCH_EN |->
    !CHIP_SEL_N && READ_N && !BUS_LINES_OE_N; endproperty
  a_din: assert property (p_din) else $error("bad data in cycle");
  property p_dout; $fell(READ_N) |-> !CHIP_SEL_N && WRITE_N && !CMD_LATCH_EN && !ADDR_LATCH_EN;
  endproperty
  a_dout: assert property (p_dout) else $error("bad data out cycle");
  property p_wide; $fell(WRITE_N) |=> !WRITE_N; endproperty
  a_wide: assert property (p_wide) else $error("write strobe too short");
  property p_flt; CHIP_SEL_N |-> BUS_LINES_OE_N; endproperty
  a_flt: assert property (p_flt) else $error("bus driven while deselected");
  property p_bsy; !READY_BUSY_N |-> ##[1:3] DEV_BUSY; endproperty
  a_bsy: assert property (p_bsy) else $error("busy line not seen");
  property p_lck; LOCK_MODE |-> ##[1:2] LOCK_FEATURE_EN; endproperty
  a_lck: assert property (p_lck) else $error("lock enable not driven");
endmodule
`default_nettype wire

// ---- nbh_dev_model.sv ----
// nbh_dev_model: behavioural flash device behind the host pins
// assumes pins change on CORE_CLK; busy line has a pull-up
`timescale 1ns/1ps
`default_nettype none
module nbh_dev_model (
  // host pins
  input wire logic CORE_CLK, CHIP_SEL_N, CMD_LATCH_EN, ADDR_LATCH_EN, WRITE_N, READ_N,
  input wire logic WRITE_GUARD_N,
  input wire logic [7:0] BUS_LINES_OUT,
  // device outputs
  output logic [7:0] BUS_LINES_IN,
  output logic READY_BUSY_N
);
  logic w_q = 1'b1, r_q = 1'b1;
  logic [7:0] last_cmd = 8'h00, last_din = 8'h00, dout = 8'h00, col = 8'h00;
  int n_addr = 0, n_prog = 0, n_rej = 0, busy = 0;
  wire logic drive = !CHIP_SEL_N && WRITE_N && !CMD_LATCH_EN && !ADDR_LATCH_EN;
  // released bus shows the inverse so a stale value never passes
  assign BUS_LINES_IN = drive ? dout : ~dout;
  assign READY_BUSY_N = (busy == 0);
  always @(posedge CORE_CLK) begin
    w_q <= WRITE_N;
    r_q <= READ_N;
    if (busy > 0) busy <= busy - 1;
    if (WRITE_N && !w_q && !CHIP_SEL_N && READ_N) begin
      if (CMD_LATCH_EN && !ADDR_LATCH_EN) begin
        last_cmd <= BUS_LINES_OUT;
        n_addr <= 0;
        if (BUS_LINES_OUT == 8'h30) busy <= 20;
        if (BUS_LINES_OUT == 8'h10 && WRITE_GUARD_N) n_prog <= n_prog + 1;
        if (BUS_LINES_OUT == 8'h10 && !WRITE_GUARD_N) n_rej <= n_rej + 1;
      end else if (ADDR_LATCH_EN && !CMD_LATCH_EN) begin
        if (n_addr < 5) n_addr <= n_addr + 1;
        col <= 8'h00;
      end else if (!CMD_LATCH_EN) last_din <= BUS_LINES_OUT;
    end
    // read mode from the start, no command needed
    if (!READ_N && r_q && drive) begin
      dout <= 8'ha0 + col;
      col <= col + 8'h01;
    end
  end
endmodule
`default_nettype wire

// ---- tb.sv ----
// tb: scenario bench for nbh_host against nbh_dev_model
// assumes the short power wait set below
`timescale 1ns/1ps
`default_nettype none
module tb;
  import nbh_pkg::*;
  logic CORE_CLK = 0, RST_B = 0, REQ_VALID = 0, PROG_ALLOWED = 1, LOCK_MODE = 0, CLK_EN = 0;
  nbh_req_t REQ = '0;
  logic REQ_READY, RSP_VALID, ADDR_COUNT_ERR, POWER_OK, DEV_BUSY, CHIP_SEL_N, CMD_LATCH_EN;
  logic ADDR_LATCH_EN, WRITE_N, READ_N, WRITE_GUARD_N, LOCK_FEATURE_EN, BUS_LINES_OE_N;
  logic READY_BUSY_N;
  logic [7:0] RSP_DATA, BUS_LINES_OUT, BUS_LINES_IN;
  int err_total = 0, tests_run = 0;
  nbh_host #(.PWR_WAIT(8)) dut (.CORE_CLK, .RST_B, .CLK_EN, .REQ_VALID, .REQ,
    .PROG_ALLOWED, .LOCK_MODE, .REQ_READY, .RSP_VALID, .RSP_DATA, .ADDR_COUNT_ERR, .POWER_OK,
    .DEV_BUSY, .CHIP_SEL_N, .CMD_LATCH_EN, .ADDR_LATCH_EN, .WRITE_N, .READ_N, .WRITE_GUARD_N,
    .LOCK_FEATURE_EN, .BUS_LINES_OUT, .BUS_LINES_OE_N, .BUS_LINES_IN, .READY_BUSY_N);
  nbh_dev_model dev (.CORE_CLK, .CHIP_SEL_N, .CMD_LATCH_EN, .ADDR_LATCH_EN, .WRITE_N,
    .READ_N, .WRITE_GUARD_N, .BUS_LINES_OUT, .BUS_LINES_IN, .READY_BUSY_N);
  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // sampled on the falling edge so settled values are seen
  task automatic wait_for(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v) begin
      @(negedge CORE_CLK);
      n++;
      if (n > 2000) begin
        err_total++;
        end_sim();
      end
    end
  endtask
  task automatic xfer(nbh_op_t op, logic [7:0] d);
    wait_for(REQ_READY, 1'b1);
    @(posedge CORE_CLK);
    REQ_VALID <= 1'b1;
    REQ <= '{op, d, 1'b0};
    wait_for(REQ_READY, 1'b0);
    @(posedge CORE_CLK);
    REQ_VALID <= 1'b0;
  endtask
  task automatic t_power;
    @(negedge CORE_CLK);
    chk("power_ok", POWER_OK, 0);
    // enable held low past the wait length: the frozen wait must not count
    repeat (12) @(negedge CORE_CLK);
    chk("power_frozen", POWER_OK, 0);
    chk("guard", WRITE_GUARD_N, 0);
    @(posedge CORE_CLK);
    CLK_EN <= 1'b1;
    wait_for(POWER_OK, 1'b1);
    wait_for(WRITE_GUARD_N, 1'b1);
  endtask
  task automatic t_write;
    xfer(NBH_OP_CMD, 8'h80);
    for (int i = 0; i < 5; i++) xfer(NBH_OP_ADDR, 8'h11 * i);
    wait_for(REQ_READY, 1'b1);
    @(posedge CORE_CLK);
    REQ_VALID <= 1'b1;
    REQ <= '{NBH_OP_ADDR, 8'h77, 1'b0};
    wait_for(ADDR_COUNT_ERR, 1'b1);
    @(posedge CORE_CLK);
    REQ_VALID <= 1'b0;
    chk("addr_count", dev.n_addr, 5);
    xfer(NBH_OP_DIN, 8'h5a);
    wait_for(REQ_READY, 1'b1);
    chk("din", dev.last_din, 8'h5a);
    chk("cmd", dev.last_cmd, 8'h80);
  endtask
  task automatic t_read;
    @(posedge CORE_CLK);
    LOCK_MODE <= 1'b1;
    xfer(NBH_OP_CMD, 8'h30);
    wait_for(DEV_BUSY, 1'b1);
    chk("ready_in_busy", REQ_READY, 0);
    for (int i = 0; i < 2; i++) begin
      xfer(NBH_OP_DOUT, 8'h00);
      wait_for(RSP_VALID, 1'b1);
      chk("rd_byte", RSP_DATA, 8'ha0 + i);
    end
    chk("lock", LOCK_FEATURE_EN, 1);
  endtask
  task automatic t_guard;
    @(posedge CORE_CLK);
    PROG_ALLOWED <= 1'b0;
    wait_for(WRITE_GUARD_N, 1'b0);
    xfer(NBH_OP_CMD, 8'h10);
    wait_for(REQ_READY, 1'b1);
    chk("prog_rej", dev.n_rej, 1);
    @(posedge CORE_CLK);
    PROG_ALLOWED <= 1'b1;
    wait_for(WRITE_GUARD_N, 1'b1);
    xfer(NBH_OP_CMD, 8'h10);
    wait_for(REQ_READY, 1'b1);
    chk("prog_ok", dev.n_prog, 1);
  endtask
  initial begin
    forever #10 CORE_CLK = ~CORE_CLK;
  end
  initial begin
    repeat (4) @(posedge CORE_CLK);
    RST_B <= 1'b1;
    t_power();
    t_write();
    t_read();
    t_guard();
    end_sim();
  end
endmodule
bind nbh_host nbh_host_properties chk_i (.CORE_CLK, .RST_B, .LOCK_MODE, .POWER_OK,
  .DEV_BUSY, .CHIP_SEL_N, .CMD_LATCH_EN, .ADDR_LATCH_EN, .WRITE_N, .READ_N, .WRITE_GUARD_N,
  .LOCK_FEATURE_EN, .BUS_LINES_OE_N, .READY_BUSY_N);
`default_nettype wire
